// *** hdl/chg_defines.svh ***
`ifndef CHG_DEFINES_SVH
`define CHG_DEFINES_SVH

// slave address and register offsets
`define CHG_I2C_ADDR 7'h47
`define CHG_OFF_VOLT_AC 8'h00
`define CHG_OFF_STAT_EOC 8'h01
`define CHG_OFF_USB 8'h02

// field positions
`define CHG_VSEL_BIT 4
`define CHG_CODE_MSB 3
`define CHG_EOC_LED_BIT 4
`define CHG_CHG_LED_BIT 3
`define CHG_EOC_SEL_MSB 2
`define CHG_EOC_SEL_LSB 1

// reset values
`define CHG_VSEL_RST 1'h0
`define CHG_AC_CODE_RST 4'h8
`define CHG_EOC_SEL_RST 2'h1
`define CHG_USB_CODE_RST 4'h8

// code limits
`define CHG_CODE_MAX 4'hD
`define CHG_CODE_USB_LOW 4'h0
`define CHG_EOC_SEL_MIN 2'h1

// timing
`define CHG_CLK_HZ 100000000.0
`define CHG_SEC_PER_HR 3600.0
`define CHG_SAFETY_TIME_HR 5.6
`define CHG_SAFETY_CYCLES (`CHG_SAFETY_TIME_HR * `CHG_SEC_PER_HR * `CHG_CLK_HZ)

`endif

// *** hdl/chg_pkg.sv ***
`default_nettype none
`include "chg_defines.svh"

package chg_pkg;

  typedef logic [40:0] chg_timer_t;

  typedef enum logic [1:0] {
    CORE_RUN = 2'b00,
    CORE_SUSPEND = 2'b01,
    CORE_FAULT = 2'b10
  } chg_core_state_e;

  typedef enum logic [3:0] {
    I2C_ADDR = 4'h0,
    I2C_ACK_ADDR = 4'h1,
    I2C_OFFSET = 4'h2,
    I2C_ACK_OFF = 4'h3,
    I2C_WDATA = 4'h4,
    I2C_ACK_WDATA = 4'h5,
    I2C_RDATA = 4'h6,
    I2C_ACK_RDATA = 4'h7,
    I2C_IGNORE = 4'h8
  } chg_i2c_state_e;

  // undefined current codes fall back to the highest defined one
  function automatic logic [3:0] clamp_code(input logic [3:0] code);
    clamp_code = (code > `CHG_CODE_MAX) ? `CHG_CODE_MAX : code;
  endfunction : clamp_code

  // undefined threshold code 0 falls back to the lowest defined one
  function automatic logic [1:0] clamp_eoc(input logic [1:0] code);
    clamp_eoc = (code < `CHG_EOC_SEL_MIN) ? `CHG_EOC_SEL_MIN : code;
  endfunction : clamp_eoc

endpackage : chg_pkg

`default_nettype wire

// *** hdl/chg_sync2.sv ***
`default_nettype none

module chg_sync2 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // data
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  import chg_pkg::*;

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end

endmodule : chg_sync2

`default_nettype wire

// *** hdl/chg_safety_timer.sv ***
`default_nettype none
`include "chg_defines.svh"

module chg_safety_timer #(
  parameter chg_pkg::chg_timer_t LIMIT = chg_pkg::chg_timer_t'(`CHG_SAFETY_CYCLES)
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic run_in,
  input wire logic clear_in,
  // status
  output logic expired_out
);
  import chg_pkg::*;

  chg_timer_t count;
  wire logic at_limit;

  assign at_limit = (count >= LIMIT);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count <= '0;
      expired_out <= 1'b0;
    end else if (clear_in) begin
      count <= '0;
      expired_out <= 1'b0;
    end else begin
      if (run_in && !at_limit) begin
        count <= count + 41'h1;
      end
      expired_out <= at_limit;
    end
  end

endmodule : chg_safety_timer

`default_nettype wire

// *** hdl/chg_config_top.sv ***
`default_nettype none
`include "chg_defines.svh"

module chg_config_top #(
  parameter chg_pkg::chg_timer_t SAFETY_CYCLES = chg_pkg::chg_timer_t'(`CHG_SAFETY_CYCLES)
) (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  // i2c link
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  // asynchronous status inputs
  input wire logic SUPPLY_SELECT_IN,
  input wire logic USB_CURRENT_SELECT_IN,
  input wire logic BATT_SUPPLY_GOOD_IN,
  input wire logic TEMP_IN_RANGE_IN,
  input wire logic CC_PHASE_IN,
  input wire logic CHARGE_DONE_IN,
  // charger control
  output logic CHARGE_ENABLE_OUT,
  output logic ADAPTOR_MODE_OUT,
  output logic VREG_SELECT_OUT,
  output logic [3:0] CURRENT_CODE_OUT,
  output logic [1:0] EOC_THRESHOLD_OUT,
  output logic CHARGE_RESTART_OUT,
  output logic SAFETY_FAULT_OUT,
  // indicators
  output logic CHG_LED_OUT,
  output logic EOC_LED_OUT
);
  import chg_pkg::*;

  // ---------------- link domain ----------------
  chg_i2c_state_e state;
  chg_i2c_state_e eff_state;
  chg_i2c_state_e next_state;
  logic start_tog;
  logic start_seen;
  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic rw;
  logic [7:0] offset;
  logic [7:0] wr_off;
  logic [7:0] wr_data;
  logic wr_tog;
  logic rd_tog;
  logic [7:0] tx;
  logic sda_oe;
  logic [7:0] rd_word;

  wire logic frame_start;
  wire logic [2:0] eff_cnt;
  wire logic [7:0] rx_byte;
  wire logic data_state;
  wire logic byte_done;
  wire logic addr_hit;
  wire logic load_tx;
  wire logic ack_drive;
  wire logic next_oe;

  // start: sda falls while scl is high; toggle is stable by the next scl rise
  always_ff @(negedge SDA_IN or posedge RST_IN) begin
    if (RST_IN) begin
      start_tog <= 1'b0;
    end else if (SCL_IN) begin
      start_tog <= ~start_tog;
    end
  end

  assign frame_start = start_tog ^ start_seen;
  assign eff_state = frame_start ? I2C_ADDR : state;
  assign eff_cnt = frame_start ? 3'h0 : bit_cnt;
  assign rx_byte = {shift, SDA_IN};
  assign data_state = (eff_state == I2C_ADDR) || (eff_state == I2C_OFFSET) ||
                      (eff_state == I2C_WDATA) || (eff_state == I2C_RDATA);
  assign byte_done = data_state && (eff_cnt == 3'h7);
  assign addr_hit = (rx_byte[7:1] == `CHG_I2C_ADDR);
  assign load_tx = ((eff_state == I2C_ACK_ADDR) && rw) ||
                   ((eff_state == I2C_ACK_RDATA) && !SDA_IN);

  always_comb begin
    next_state = eff_state;
    unique case (eff_state)
      I2C_ADDR: begin
        if (byte_done) begin
          next_state = addr_hit ? I2C_ACK_ADDR : I2C_IGNORE;
        end
      end
      I2C_OFFSET: begin
        if (byte_done) begin
          next_state = I2C_ACK_OFF;
        end
      end
      I2C_WDATA: begin
        if (byte_done) begin
          next_state = I2C_ACK_WDATA;
        end
      end
      I2C_RDATA: begin
        if (byte_done) begin
          next_state = I2C_ACK_RDATA;
        end
      end
      I2C_ACK_ADDR: begin
        next_state = rw ? I2C_RDATA : I2C_OFFSET;
      end
      I2C_ACK_OFF: begin
        next_state = I2C_WDATA;
      end
      I2C_ACK_WDATA: begin
        next_state = I2C_IGNORE;
      end
      I2C_ACK_RDATA: begin
        next_state = SDA_IN ? I2C_IGNORE : I2C_RDATA;
      end
      I2C_IGNORE: begin
        next_state = I2C_IGNORE;
      end
      default: begin
        next_state = I2C_IGNORE;
      end
    endcase
  end

  always_ff @(posedge SCL_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state <= I2C_IGNORE;
      start_seen <= 1'b0;
      bit_cnt <= 3'h0;
      shift <= 7'h00;
    end else begin
      state <= next_state;
      start_seen <= start_tog;
      bit_cnt <= data_state ? eff_cnt + 3'h1 : 3'h0;
      shift <= rx_byte[6:0];
    end
  end

  // offset and write data stay stable between toggles for the core to capture
  always_ff @(posedge SCL_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rw <= 1'b0;
      offset <= 8'h00;
      wr_off <= 8'h00;
      wr_data <= 8'h00;
      wr_tog <= 1'b0;
      rd_tog <= 1'b0;
      tx <= 8'h00;
    end else begin
      if ((eff_state == I2C_ADDR) && byte_done) begin
        rw <= rx_byte[0];
      end
      if ((eff_state == I2C_OFFSET) && byte_done) begin
        offset <= rx_byte;
        rd_tog <= ~rd_tog;
      end
      if ((eff_state == I2C_WDATA) && byte_done) begin
        wr_off <= offset;
        wr_data <= rx_byte;
        wr_tog <= ~wr_tog;
      end
      if (load_tx) begin
        tx <= rd_word;
      end
    end
  end

  assign ack_drive = (state == I2C_ACK_ADDR) || (state == I2C_ACK_OFF) ||
                     (state == I2C_ACK_WDATA);
  assign next_oe = ack_drive || ((state == I2C_RDATA) && !tx[~bit_cnt]);

  // sda changes only while scl is low
  always_ff @(negedge SCL_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= next_oe;
    end
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE_OUT = sda_oe;

  // ---------------- core domain ----------------
  logic [7:0] sync_q;
  wire logic supply_sel;
  wire logic usb_current_select_input;
  wire logic batt_good;
  wire logic temp_ok;
  wire logic cc_phase;
  wire logic charge_done;
  wire logic wr_tog_s;
  wire logic rd_tog_s;

  chg_sync2 #(
    .WIDTH(8)
  ) u_sync (
    .clk_in(CORE_CLK_IN),
    .rst_in(RST_IN),
    .d_in({CHARGE_DONE_IN, CC_PHASE_IN, TEMP_IN_RANGE_IN, BATT_SUPPLY_GOOD_IN,
           USB_CURRENT_SELECT_IN, SUPPLY_SELECT_IN, rd_tog, wr_tog}),
    .q_out(sync_q)
  );

  assign wr_tog_s = sync_q[0];
  assign rd_tog_s = sync_q[1];
  assign supply_sel = sync_q[2];
  assign usb_current_select_input = sync_q[3];
  assign batt_good = sync_q[4];
  assign temp_ok = sync_q[5];
  assign cc_phase = sync_q[6];
  assign charge_done = sync_q[7];

  logic wr_seen;
  logic rd_seen;
  logic temp_ok_d;
  logic cc_phase_d;
  logic vsel;
  logic [3:0] ac_code;
  logic [1:0] eoc_sel;
  logic [3:0] usb_code;
  chg_core_state_e core_state;
  chg_core_state_e next_core_state;
  logic timer_expired;

  wire logic wr_evt;
  wire logic rd_evt;
  wire logic wr_reg0;
  wire logic wr_reg1;
  wire logic wr_reg2;
  wire logic [7:0] reg0_byte;
  wire logic [7:0] reg1_byte;
  wire logic [7:0] reg2_byte;
  wire logic [7:0] next_rd_word;
  wire logic temp_recover;
  wire logic cc_entry;
  wire logic timer_run;
  wire logic timer_clear;
  wire logic [3:0] next_code;

  assign wr_evt = wr_tog_s ^ wr_seen;
  assign rd_evt = rd_tog_s ^ rd_seen;
  assign wr_reg0 = wr_evt && (wr_off == `CHG_OFF_VOLT_AC);
  assign wr_reg1 = wr_evt && (wr_off == `CHG_OFF_STAT_EOC);
  assign wr_reg2 = wr_evt && (wr_off == `CHG_OFF_USB);

  // status bits come from the indicator flops and cannot be written
  assign reg0_byte = {3'h0, vsel, ac_code};
  assign reg1_byte = {3'h0, EOC_LED_OUT, CHG_LED_OUT, eoc_sel, 1'b0};
  assign reg2_byte = {4'h0, usb_code};
  assign next_rd_word = (offset == `CHG_OFF_VOLT_AC) ? reg0_byte :
                        (offset == `CHG_OFF_STAT_EOC) ? reg1_byte :
                        (offset == `CHG_OFF_USB) ? reg2_byte : 8'h00;

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wr_seen <= 1'b0;
      rd_seen <= 1'b0;
      rd_word <= 8'h00;
    end else begin
      wr_seen <= wr_tog_s;
      rd_seen <= rd_tog_s;
      if (rd_evt) begin
        rd_word <= next_rd_word;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      vsel <= `CHG_VSEL_RST;
      ac_code <= `CHG_AC_CODE_RST;
      eoc_sel <= `CHG_EOC_SEL_RST;
      usb_code <= `CHG_USB_CODE_RST;
    end else if (!batt_good) begin
      vsel <= `CHG_VSEL_RST;
      ac_code <= `CHG_AC_CODE_RST;
      eoc_sel <= `CHG_EOC_SEL_RST;
      usb_code <= `CHG_USB_CODE_RST;
    end else begin
      if (wr_reg0) begin
        vsel <= wr_data[`CHG_VSEL_BIT];
        ac_code <= wr_data[`CHG_CODE_MSB:0];
      end
      if (wr_reg1) begin
        eoc_sel <= wr_data[`CHG_EOC_SEL_MSB:`CHG_EOC_SEL_LSB];
      end
      if (wr_reg2) begin
        usb_code <= wr_data[`CHG_CODE_MSB:0];
      end
    end
  end

  assign temp_recover = temp_ok && !temp_ok_d;
  assign cc_entry = cc_phase && !cc_phase_d;
  assign timer_run = (core_state == CORE_RUN) && cc_phase;
  assign timer_clear = temp_recover || cc_entry;

  chg_safety_timer #(
    .LIMIT(SAFETY_CYCLES)
  ) u_timer (
    .clk_in(CORE_CLK_IN),
    .rst_in(RST_IN),
    .run_in(timer_run),
    .clear_in(timer_clear),
    .expired_out(timer_expired)
  );

  always_comb begin
    next_core_state = core_state;
    unique case (core_state)
      CORE_RUN: begin
        if (!temp_ok) begin
          next_core_state = CORE_SUSPEND;
        end else if (timer_expired && cc_phase) begin
          next_core_state = CORE_FAULT;
        end
      end
      CORE_SUSPEND: begin
        if (temp_ok) begin
          next_core_state = CORE_RUN;
        end
      end
      CORE_FAULT: begin
        if (!temp_ok) begin
          next_core_state = CORE_SUSPEND;
        end
      end
      default: begin
        next_core_state = CORE_SUSPEND;
      end
    endcase
  end

  // adaptor code, or usb code unless current select forces the low setting
  assign next_code = supply_sel ? clamp_code(ac_code) :
                     usb_current_select_input ? `CHG_CODE_USB_LOW : clamp_code(usb_code);

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      temp_ok_d <= 1'b0;
      cc_phase_d <= 1'b0;
      core_state <= CORE_SUSPEND;
      CHARGE_ENABLE_OUT <= 1'b0;
      ADAPTOR_MODE_OUT <= 1'b0;
      VREG_SELECT_OUT <= 1'b0;
      CURRENT_CODE_OUT <= 4'h0;
      EOC_THRESHOLD_OUT <= 2'h0;
      CHARGE_RESTART_OUT <= 1'b0;
      SAFETY_FAULT_OUT <= 1'b0;
      CHG_LED_OUT <= 1'b0;
      EOC_LED_OUT <= 1'b0;
    end else begin
      temp_ok_d <= temp_ok;
      cc_phase_d <= cc_phase;
      core_state <= next_core_state;
      CHARGE_ENABLE_OUT <= (next_core_state == CORE_RUN);
      ADAPTOR_MODE_OUT <= supply_sel;
      VREG_SELECT_OUT <= vsel;
      CURRENT_CODE_OUT <= next_code;
      EOC_THRESHOLD_OUT <= clamp_eoc(eoc_sel);
      CHARGE_RESTART_OUT <= temp_recover;
      SAFETY_FAULT_OUT <= (next_core_state == CORE_FAULT);
      CHG_LED_OUT <= (next_core_state != CORE_RUN) || !charge_done;
      EOC_LED_OUT <= (next_core_state != CORE_RUN) || charge_done;
    end
  end

endmodule : chg_config_top

`default_nettype wire

// *** test/chg_config_top_assertions.sv ***
`default_nettype none
module chg_config_top_assertions #(
  parameter chg_pkg::chg_timer_t SAFETY_CYCLES = 41'h00c8
) (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  // link
  input wire logic SCL_IN,
  input wire logic SDA_OE_OUT,
  // status inputs
  input wire logic SUPPLY_SELECT_IN,
  input wire logic USB_CURRENT_SELECT_IN,
  input wire logic BATT_SUPPLY_GOOD_IN,
  input wire logic TEMP_IN_RANGE_IN,
  input wire logic CC_PHASE_IN,
  input wire logic CHARGE_DONE_IN,
  // charger control and indicators
  input wire logic CHARGE_ENABLE_OUT,
  input wire logic ADAPTOR_MODE_OUT,
  input wire logic VREG_SELECT_OUT,
  input wire logic [3:0] CURRENT_CODE_OUT,
  input wire logic [1:0] EOC_THRESHOLD_OUT,
  input wire logic CHARGE_RESTART_OUT,
  input wire logic SAFETY_FAULT_OUT,
  input wire logic CHG_LED_OUT,
  input wire logic EOC_LED_OUT
);
  import chg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  chg_timer_t run_cnt;
  chg_timer_t next_run_cnt;

  // cycles spent charging with the constant-current phase requested
  assign next_run_cnt = (CC_PHASE_IN && CHARGE_ENABLE_OUT) ? run_cnt + 1'b1 : '0;

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      run_cnt <= '0;
    end else begin
      run_cnt <= next_run_cnt;
    end
  end

  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  timer_late_a: assert property (run_cnt <= SAFETY_CYCLES + 8)
    else $error("safety timer did not expire in time");
  timer_early_a: assert property (
      $rose(SAFETY_FAULT_OUT) |-> run_cnt >= SAFETY_CYCLES - 8)
    else $error("safety fault came too early");
  fault_leds_a: assert property (
      SAFETY_FAULT_OUT |-> CHG_LED_OUT && EOC_LED_OUT && !CHARGE_ENABLE_OUT)
    else $error("fault without both indicators and charge off");
  fault_stay_a: assert property (
      (SAFETY_FAULT_OUT && TEMP_IN_RANGE_IN) [*4] |=> SAFETY_FAULT_OUT)
    else $error("fault left without temperature cycle");
  susp_state_a: assert property (
      !TEMP_IN_RANGE_IN [*6] |-> !CHARGE_ENABLE_OUT && CHG_LED_OUT && EOC_LED_OUT)
    else $error("charging not suspended on temperature loss");
  restart_run_a: assert property (
      CHARGE_RESTART_OUT |-> ##1 !CHARGE_RESTART_OUT ##[0:3] CHARGE_ENABLE_OUT)
    else $error("restart pulse not followed by charging");
  run_leds_a: assert property (($stable(CHARGE_DONE_IN) && CHARGE_ENABLE_OUT) [*5]
      |-> EOC_LED_OUT == CHARGE_DONE_IN && CHG_LED_OUT != CHARGE_DONE_IN)
    else $error("indicators disagree with charge state");
  usb_low_a: assert property ((!SUPPLY_SELECT_IN && USB_CURRENT_SELECT_IN) [*6]
      |-> CURRENT_CODE_OUT == 4'h0)
    else $error("usb low current select not applied");
  mode_follow_a: assert property ($stable(SUPPLY_SELECT_IN) [*6]
      |-> ADAPTOR_MODE_OUT == SUPPLY_SELECT_IN)
    else $error("supply mode does not follow select input");
  code_range_a: assert property (!$past(RST_IN, 3)
      |-> CURRENT_CODE_OUT <= 4'hd && EOC_THRESHOLD_OUT != 2'h0)
    else $error("undefined code reached charger control");
  batt_dflt_a: assert property (!BATT_SUPPLY_GOOD_IN [*6]
      |-> !VREG_SELECT_OUT && EOC_THRESHOLD_OUT == 2'h1)
    else $error("settings kept without battery supply good");
  oe_steady_a: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE_OUT))
    else $error("data line changed while clock high");
endmodule : chg_config_top_assertions

bind chg_config_top chg_config_top_assertions #(.SAFETY_CYCLES(SAFETY_CYCLES)) u_chk (.*);
`default_nettype wire

// *** test/chg_i2c_master.sv ***
`default_nettype none
module chg_i2c_master (
  // bus lines
  output var logic scl_out,
  output var logic pull_out,
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam real Q = 31.25;

  // clock stands high and data released between frames
  initial begin
    scl_out = 1'b1;
    pull_out = 1'b0;
  end

  task automatic bit_io(input logic b, output logic r);
    pull_out = ~b;
    #Q scl_out = 1'b1;
    #Q r = sda_in;
    #Q scl_out = 1'b0;
    #Q;
  endtask : bit_io

  // also serves as repeated start
  task automatic start();
    pull_out = 1'b0;
    #Q scl_out = 1'b1;
    #Q pull_out = 1'b1;
    #Q scl_out = 1'b0;
    #Q;
  endtask : start

  task automatic stop();
    pull_out = 1'b1;
    #Q scl_out = 1'b1;
    #Q pull_out = 1'b0;
    #Q;
  endtask : stop

  task automatic xfer(input logic [7:0] tx, input logic mb, output logic [7:0] rx,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(mb, s);
    ack = ~s;
  endtask : xfer

  task automatic wr(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d,
                    output logic [2:0] ack);
    logic [7:0] rx;
    start();
    xfer({a, 1'b0}, 1'b1, rx, ack[2]);
    xfer(off, 1'b1, rx, ack[1]);
    xfer(d, 1'b1, rx, ack[0]);
    stop();
  endtask : wr

  task automatic rd(input logic [7:0] off, output logic [7:0] d, output logic [2:0] ack);
    logic [7:0] rx;
    logic n;
    start();
    xfer({7'h47, 1'b0}, 1'b1, rx, ack[2]);
    xfer(off, 1'b1, rx, ack[1]);
    start();
    xfer({7'h47, 1'b1}, 1'b1, rx, ack[0]);
    xfer(8'hff, 1'b1, d, n);
    stop();
  endtask : rd
endmodule : chg_i2c_master
`default_nettype wire

// *** test/tb_top.sv ***
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM = 200;
  logic clk, rst, pull, sup, usb_current_select_input, batt, temp, cc, done, sda;
  logic scl, sda_o, sda_oe, en, mode, vreg, restart, fault, chg_led, eoc_led;
  logic [3:0] code;
  logic [1:0] thr;
  logic [31:0] s = 32'h0000_77e9;
  logic [7:0] msk [4] = '{8'h1f, 8'h06, 8'h0f, 8'h00};
  logic [7:0] tbl [3] = '{8'h1f, 8'h00, 8'h0e};
  int m [4] = '{8, 2, 8, 0};
  int st = 8;
  int errors = 0;
  int comparisons = 0;
  int restarts = 0;
  int cyc = 0;

  // open-drain data line with pull-up
  assign sda = !(pull || (sda_oe && !sda_o));

  chg_config_top #(.SAFETY_CYCLES(chg_pkg::chg_timer_t'(LIM))) uut (
    .CORE_CLK_IN(clk), .RST_IN(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o),
    .SDA_OE_OUT(sda_oe), .SUPPLY_SELECT_IN(sup), .USB_CURRENT_SELECT_IN(usb_current_select_input),
    .BATT_SUPPLY_GOOD_IN(batt), .TEMP_IN_RANGE_IN(temp), .CC_PHASE_IN(cc),
    .CHARGE_DONE_IN(done), .CHARGE_ENABLE_OUT(en), .ADAPTOR_MODE_OUT(mode),
    .VREG_SELECT_OUT(vreg), .CURRENT_CODE_OUT(code), .EOC_THRESHOLD_OUT(thr),
    .CHARGE_RESTART_OUT(restart), .SAFETY_FAULT_OUT(fault), .CHG_LED_OUT(chg_led),
    .EOC_LED_OUT(eoc_led)
  );

  chg_i2c_master mst (.scl_out(scl), .pull_out(pull), .sda_in(sda));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  function automatic logic [7:0] ecode();
    int c;
    c = sup ? m[0] % 16 : (usb_current_select_input ? 0 : m[2]);
    return 8'(c > 13 ? 13 : c);
  endfunction : ecode

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // outputs, then registers lo..hi read back over the link
  task automatic chk(input int lo, input int hi);
    logic [7:0] d;
    logic [2:0] a;
    check("vreg", 8'(vreg), 8'(m[0] >> 4));
    check("code", 8'(code), ecode());
    check("thr", 8'(thr), 8'((m[1] >> 1) == 0 ? 1 : m[1] >> 1));
    check("mode", 8'(mode), 8'(sup));
    for (int o = lo; o <= hi; o++) begin
      mst.rd(8'(o), d, a);
      check("rack", 8'(a), 8'h07);
      check("reg", d, 8'(o == 1 ? m[1] | st : m[o]));
    end
  endtask : chk

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // sampled off the launching edge so the one-cycle pulse is seen settled
  always @(negedge clk) begin
    cyc++;
    if (restart === 1'b1) restarts++;
    if (cyc == 40000) begin
      errors++;
      results();
    end
  end

  initial begin
    logic [2:0] a;
    logic [7:0] d;
    int o;
    {rst, sup, usb_current_select_input, batt, temp, cc, done} = 7'h6c;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (20) @(negedge clk);
    chk(0, 3);
    for (int i = 0; i < 14; i++) begin
      s = lfsr(s);
      o = i < 3 ? i : int'(s[1:0]);
      d = i < 3 ? tbl[i] : s[15:8];
      @(negedge clk);
      {sup, usb_current_select_input, done} = s[18:16];
      mst.wr(7'h47, 8'(o), d, a);
      check("wack", 8'(a[2:1]), 8'h03);
      m[o] = d & msk[o];
      st = done ? 8'h10 : 8'h08;
      repeat (8) @(negedge clk);
      chk(o, o);
    end
    @(negedge clk);
    mst.wr(7'h46, 8'h00, 8'h13, a);
    check("nack", 8'(a), 8'h00);
    @(negedge clk);
    {sup, done} = 2'b10;
    batt = 1'b0;
    st = 8'h08;
    repeat (8) @(negedge clk);
    m = '{8, 2, 8, 0};
    chk(0, 2);
    @(negedge clk);
    mst.wr(7'h47, 8'h00, 8'h1a, a);
    @(negedge clk);
    batt = 1'b1;
    repeat (8) @(negedge clk);
    chk(0, 3);
    @(negedge clk);
    cc = 1'b1;
    repeat (LIM - 50) @(negedge clk);
    check("early", 8'(fault), 8'h00);
    repeat (70) @(negedge clk);
    check("fault", 8'({fault, en, chg_led, eoc_led}), 8'h0b);
    st = 8'h18;
    chk(1, 1);
    @(negedge clk);
    temp = 1'b0;
    repeat (10) @(negedge clk);
    check("susp", 8'({fault, en, chg_led, eoc_led}), 8'h03);
    restarts = 0;
    temp = 1'b1;
    repeat (LIM - 50) @(negedge clk);
    check("restart", 8'(restarts), 8'h01);
    check("rerun", 8'({fault, en}), 8'h01);
    repeat (70) @(negedge clk);
    check("refault", 8'(fault), 8'h01);
    results();
  end
endmodule : tb_top
`default_nettype wire
